// *** rtl/xio_pkg.sv ***
//==================================================================
// register map, field layout and conversion constants
package xio_pkg;

   localparam int unsigned XIO_ADDR_W      = 20;
   localparam int unsigned XIO_DATA_W      = 32;
   localparam int unsigned XIO_LINES       = 24;
   localparam int unsigned XIO_GROUPS      = 3;
   localparam int unsigned XIO_LEVELS      = 4;
   localparam int unsigned XIO_CODE_W      = 12;

   // register indices; byte address is four times the index
   localparam logic [17:0] XIO_IDX_DIR     = 18'h0B7FC;
   localparam logic [17:0] XIO_IDX_DATA    = 18'h0B806;
   localparam logic [17:0] XIO_IDX_LEVEL0  = 18'h0B810;
   localparam logic [17:0] XIO_IDX_LEVEL1  = 18'h0B811;
   localparam logic [17:0] XIO_IDX_LEVEL2  = 18'h0B812;
   localparam logic [17:0] XIO_IDX_LEVEL3  = 18'h0B813;
   localparam logic [17:0] XIO_IDX_UPDATE  = 18'h0B81A;

   // direction codes, one bit per byte group
   localparam logic [2:0]  XIO_LOW_BYTE_AS_OUTPUT    = 3'h1;
   localparam logic [2:0]  XIO_MIDDLE_BYTE_AS_OUTPUT = 3'h2;
   localparam logic [2:0]  XIO_HIGH_BYTE_AS_OUTPUT   = 3'h4;
   localparam logic [2:0]  XIO_ALL_AS_INPUT          = 3'h0;

   // update strobe trigger value
   localparam logic [31:0] XIO_UPDATE_GO   = 32'h0000_0001;

   // level range in millivolts
   localparam logic signed [15:0] XIO_MV_MAX = 16'sh2710;
   localparam logic signed [15:0] XIO_MV_MIN = -16'sh2710;

   // code = (mv + 10000) * 4095 / 20000, as a multiply by 2**-20 scale
   localparam logic [17:0] XIO_CODE_MULT   = 18'h346A8;
   localparam int unsigned XIO_CODE_SHIFT  = 20;

   // reset values
   localparam logic [2:0]  XIO_DIR_RST     = 3'h0;
   localparam logic [23:0] XIO_DATA_RST    = 24'h00_0000;
   localparam logic [15:0] XIO_LEVEL_RST   = 16'h0000;
   localparam logic [11:0] XIO_CODE_RST    = 12'h7FF;

   typedef logic signed [15:0] xio_level_t;

   function automatic logic [11:0] xio_mv_to_code(input logic signed [15:0] mv);
      logic [15:0] off;
      logic [33:0] prod;
      off  = 16'(mv - XIO_MV_MIN);
      prod = 34'(off) * 34'(XIO_CODE_MULT);
      return prod[31:20];
   endfunction : xio_mv_to_code

endpackage : xio_pkg

// *** rtl/xio_top.sv ***
// Chosen here: register access over APB.
`timescale 1ns/1ns
`default_nettype none

//==================================================================
module xio_top
   import xio_pkg::*;
(
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [XIO_ADDR_W-1:0]   paddr,
   input  wire logic [XIO_DATA_W-1:0]   pwdata,
   output var  logic [XIO_DATA_W-1:0]   prdata,
   output var  logic                    pready,
   output var  logic                    pslverr,
   input  wire logic [XIO_LINES-1:0]    line_in,
   output var  logic [XIO_LINES-1:0]    line_out,
   output var  logic [XIO_LINES-1:0]    line_oe,
   output var  logic [XIO_CODE_W-1:0]   dac_code_0,
   output var  logic [XIO_CODE_W-1:0]   dac_code_1,
   output var  logic [XIO_CODE_W-1:0]   dac_code_2,
   output var  logic [XIO_CODE_W-1:0]   dac_code_3,
   output var  logic                    dac_load
);

   //==================================================================
   // state
   logic [2:0]                  dir_reg;
   logic [2:0]                  dir_next;
   logic [XIO_LINES-1:0]        out_reg;
   logic [XIO_LINES-1:0]        out_next;
   logic [XIO_LINES-1:0]        oe_reg;
   logic [XIO_LINES-1:0]        oe_next;
   xio_level_t                  level_reg [XIO_LEVELS];
   xio_level_t                  level_next [XIO_LEVELS];
   logic [XIO_CODE_W-1:0]       code_reg [XIO_LEVELS];
   logic [XIO_CODE_W-1:0]       code_next [XIO_LEVELS];
   logic                        load_reg;
   logic                        load_next;
   logic [XIO_DATA_W-1:0]       rdata_reg;
   logic [XIO_DATA_W-1:0]       rdata_next;
   logic                        ready_reg;
   logic                        ready_next;
   logic                        err_reg;
   logic                        err_next;

   //==================================================================
   // bus decode
   logic                        setup_cyc;
   logic                        wr_acc;
   logic [17:0]                 idx;
   logic                        aligned;
   logic                        hit_dir;
   logic                        hit_data;
   logic                        hit_upd;
   logic [3:0]                  hit_lvl;
   logic                        mapped;
   xio_level_t                  wr_level;

   assign setup_cyc = psel & ~penable;
   // writes land only at the access edge the slave acknowledges
   assign wr_acc    = psel & penable & pwrite & ready_reg & ~err_reg;
   assign idx       = paddr[XIO_ADDR_W-1:2];
   assign aligned   = (paddr[1:0] == 2'h0);
   assign hit_dir   = aligned & (idx == XIO_IDX_DIR);
   assign hit_data  = aligned & (idx == XIO_IDX_DATA);
   assign hit_upd   = aligned & (idx == XIO_IDX_UPDATE);
   assign hit_lvl[0] = aligned & (idx == XIO_IDX_LEVEL0);
   assign hit_lvl[1] = aligned & (idx == XIO_IDX_LEVEL1);
   assign hit_lvl[2] = aligned & (idx == XIO_IDX_LEVEL2);
   assign hit_lvl[3] = aligned & (idx == XIO_IDX_LEVEL3);
   assign mapped    = hit_dir | hit_data | hit_upd | (|hit_lvl);

   // out-of-range values saturate so the converter never wraps
   always_comb
   begin
      if ($signed(pwdata) > 32'(XIO_MV_MAX))
         wr_level = XIO_MV_MAX;
      else if ($signed(pwdata) < 32'(XIO_MV_MIN))
         wr_level = XIO_MV_MIN;
      else
         wr_level = pwdata[15:0];
   end

   //==================================================================
   // bus answer: one wait-free access phase, error on unmapped words
   always_comb
   begin
      ready_next = setup_cyc;
      err_next   = setup_cyc & ~mapped;
      rdata_next = rdata_reg;
      if (setup_cyc & ~pwrite)
      begin
         rdata_next = '0;
         if (hit_dir)
            rdata_next = {29'h0000_0000, dir_reg};
         if (hit_data)
            rdata_next = {8'h00, line_in};
         for (int i = 0; i < XIO_LEVELS; i++)
            if (hit_lvl[i])
               rdata_next = {{16{level_reg[i][15]}}, level_reg[i]};
      end
   end

   //==================================================================
   // direction and line data
   always_comb
   begin
      dir_next = dir_reg;
      out_next = out_reg;
      if (wr_acc & hit_dir)
         dir_next = pwdata[2:0];
      // lines only move on a software write, never on any sample clock
      if (wr_acc & hit_data)
         for (int g = 0; g < XIO_GROUPS; g++)
            if (dir_reg[g])
               out_next[g*8 +: 8] = pwdata[g*8 +: 8];
   end

   genvar gb;
   generate
      for (gb = 0; gb < XIO_GROUPS; gb++)
      begin : g_grp
         assign oe_next[gb*8 +: 8] = {8{dir_next[gb]}};
      end
   endgenerate

   //==================================================================
   // analog levels and converter load
   always_comb
   begin
      load_next = 1'b0;
      for (int i = 0; i < XIO_LEVELS; i++)
      begin
         level_next[i] = level_reg[i];
         code_next[i]  = code_reg[i];
         if (wr_acc & hit_lvl[i])
            level_next[i] = wr_level;
      end
      if (wr_acc & hit_upd & (pwdata == XIO_UPDATE_GO))
      begin
         load_next = 1'b1;
         for (int i = 0; i < XIO_LEVELS; i++)
            code_next[i] = xio_mv_to_code(level_reg[i]);
      end
   end

   //==================================================================
   // registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dir_reg   <= XIO_DIR_RST;
         out_reg   <= XIO_DATA_RST;
         oe_reg    <= '0;
         load_reg  <= 1'b0;
         rdata_reg <= '0;
         ready_reg <= 1'b0;
         err_reg   <= 1'b0;
         for (int i = 0; i < XIO_LEVELS; i++)
         begin
            level_reg[i] <= XIO_LEVEL_RST;
            code_reg[i]  <= XIO_CODE_RST;
         end
      end
      else
      begin
         dir_reg   <= dir_next;
         out_reg   <= out_next;
         oe_reg    <= oe_next;
         load_reg  <= load_next;
         rdata_reg <= rdata_next;
         ready_reg <= ready_next;
         err_reg   <= err_next;
         for (int i = 0; i < XIO_LEVELS; i++)
         begin
            level_reg[i] <= level_next[i];
            code_reg[i]  <= code_next[i];
         end
      end
   end

   assign prdata     = rdata_reg;
   assign pready     = ready_reg;
   assign pslverr    = err_reg;
   assign line_out   = out_reg;
   assign line_oe    = oe_reg;
   assign dac_code_0 = code_reg[0];
   assign dac_code_1 = code_reg[1];
   assign dac_code_2 = code_reg[2];
   assign dac_code_3 = code_reg[3];
   assign dac_load   = load_reg;

   //==================================================================
   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_wr(logic hit);
      psel && penable && pwrite && pready && !pslverr && hit;
   endsequence

   sequence s_rd_setup(logic hit);
      psel && !penable && !pwrite && hit;
   endsequence

   a_group_enable: assert property (
      line_oe == {{8{dir_reg[2]}}, {8{dir_reg[1]}}, {8{dir_reg[0]}}})
      else $error("group enables disagree with direction");

   a_dir_write: assert property (s_wr(hit_dir) |=>
      line_oe == {{8{$past(pwdata[2])}}, {8{$past(pwdata[1])}}, {8{$past(pwdata[0])}}})
      else $error("direction write did not set the groups");

   a_data_map: assert property (s_wr(hit_data && dir_reg == 3'h7) |=>
      line_out == $past(pwdata[23:0]))
      else $error("line data not mapped bit for bit");

   a_pin_read: assert property (s_rd_setup(hit_data) |=>
      pready && prdata[23:0] == $past(line_in))
      else $error("line data read is not the pin levels");

   a_input_hold: assert property (s_wr(hit_data && !dir_reg[1]) |=>
      $stable(line_out[15:8]))
      else $error("input group changed by a write");

   a_top_byte: assert property (s_rd_setup(hit_data) |=> prdata[31:24] == 8'h00)
      else $error("top byte of line data not zero");

   a_quiet_lines: assert property (!(psel && penable && pwrite) |=>
      $stable(line_out) && $stable(line_oe))
      else $error("lines moved without a write");

   a_level_range: assert property (
      $signed(level_reg[0]) <= XIO_MV_MAX && $signed(level_reg[0]) >= XIO_MV_MIN)
      else $error("level outside range");

   a_code_conv: assert property (s_wr(hit_upd && pwdata == XIO_UPDATE_GO) |=>
      dac_load && dac_code_2 == xio_mv_to_code($past(level_reg[2])))
      else $error("converter code not from stored level");

   // all four codes must come from one snapshot of the stored levels
   a_code_rest: assert property (s_wr(hit_upd && pwdata == XIO_UPDATE_GO) |=>
      dac_code_0 == xio_mv_to_code($past(level_reg[0])) &&
      dac_code_1 == xio_mv_to_code($past(level_reg[1])) &&
      dac_code_3 == xio_mv_to_code($past(level_reg[3])))
      else $error("converter codes not loaded together");

   a_codes_hold: assert property (!dac_load |->
      $stable(dac_code_0) && $stable(dac_code_1) &&
      $stable(dac_code_2) && $stable(dac_code_3))
      else $error("converter code moved without a load");

   a_load_pulse: assert property (dac_load |=> !dac_load)
      else $error("converter load longer than one cycle");

   a_level_read: assert property (s_rd_setup(hit_lvl[1]) |=>
      prdata == {{16{level_reg[1][15]}}, level_reg[1]})
      else $error("level read is not the stored value");

   a_level_quiet: assert property (s_wr(|hit_lvl) |=>
      $stable(dac_code_0) && $stable(dac_code_3) && !dac_load)
      else $error("level write moved an output");

   a_strobe_other: assert property (s_wr(hit_upd && pwdata != XIO_UPDATE_GO) |=>
      !dac_load && $stable(dac_code_1))
      else $error("non-one update moved an output");

   a_one_wait: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("access phase not answered in one cycle");

   a_dir_read: assert property (s_rd_setup(hit_dir) |=>
      prdata == {29'h0, dir_reg})
      else $error("direction read is not the stored code");

   a_err_refused: assert property (s_rd_setup(!mapped) |=>
      pready && pslverr && prdata == '0)
      else $error("unmapped read not refused");

   a_err_clear: assert property (s_rd_setup(mapped) |=> pready && !pslverr)
      else $error("mapped read answered with an error");

   // saturation must hold for every level, not only the first
   for (gb = 0; gb < XIO_LEVELS; gb++)
   begin : g_lvl_chk
      a_level_bound: assert property (
         level_reg[gb] <= XIO_MV_MAX && level_reg[gb] >= XIO_MV_MIN)
         else $error("stored level outside range");
   end

endmodule : xio_top

`default_nettype wire

// *** tb/xio_ext_model.sv ***
`timescale 1ns/1ns
`default_nettype none

//==================================================================
// external equipment on the auxiliary lines
module xio_ext_model (
   input  wire logic [23:0] line_out,
   input  wire logic [23:0] line_oe,
   input  wire logic [23:0] ext_drive,
   output var  logic [23:0] line_in
);
   // the device wins where it drives, the equipment elsewhere, so no line floats
   always_comb line_in = (line_oe & line_out) | (~line_oe & ext_drive);
endmodule : xio_ext_model

`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none

//==================================================================
// bench: apb master, reference model, checks
module tb_top
   import xio_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, dac_load, er;
   logic [19:0] paddr;
   logic [31:0] pwdata, prdata, rd, w;
   logic [23:0] line_in, line_out, line_oe, ext_drive, out_m, msk;
   logic [11:0] dac_code_0, dac_code_1, dac_code_2, dac_code_3;
   integer      error_cnt, check_count, load_cnt, seed, d, k, v;
   integer      lvl_m[4];
   integer      code_m[4];

   xio_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
      .dac_code_0(dac_code_0), .dac_code_1(dac_code_1), .dac_code_2(dac_code_2),
      .dac_code_3(dac_code_3), .dac_load(dac_load));

   xio_ext_model i_ext (.line_out(line_out), .line_oe(line_oe), .ext_drive(ext_drive),
      .line_in(line_in));

   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   always @(posedge pclk)
      if (dac_load === 1'b1)
         load_cnt = load_cnt + 1;

   task automatic finish_test();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test

   task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count = check_count + 1;
      if (g !== e)
      begin
         error_cnt = error_cnt + 1;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk_reg

   task automatic chk_pin(input string n, input logic [23:0] e, input logic [23:0] g);
      check_count = check_count + 1;
      if (g !== e)
      begin
         error_cnt = error_cnt + 1;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk_pin

   task automatic chk_dac();
      chk_pin("dac0", 24'(code_m[0]), 24'(dac_code_0));
      chk_pin("dac1", 24'(code_m[1]), 24'(dac_code_1));
      chk_pin("dac2", 24'(code_m[2]), 24'(dac_code_2));
      chk_pin("dac3", 24'(code_m[3]), 24'(dac_code_3));
   endtask : chk_dac

   // one transfer; the master holds everything until pready is seen high or 16 access cycles pass
   task automatic apb(input logic wr, input logic [17:0] idx, input logic [31:0] wd);
      integer n;
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n = n + 1;
      end
      while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (n >= 16)
         chk_reg("pready", 32'h1, 32'h0);
   endtask : apb

   initial
   begin
      repeat (4000) @(posedge pclk);
      error_cnt = error_cnt + 1;
      finish_test();
   end

   initial
   begin
      error_cnt = 0;
      check_count = 0;
      load_cnt = 0;
      seed = 32'h7afe;
      out_m = 24'h00_0000;
      {presetn, psel, penable, pwrite, paddr, pwdata, ext_drive} = '0;
      for (k = 0; k < 4; k++)
         code_m[k] = 2047;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk_pin("oe", 24'h00_0000, line_oe);
      chk_dac();
      // every direction code, random data including the ignored top byte
      for (d = 0; d < 8; d++)
      begin
         msk = {{8{d[2]}}, {8{d[1]}}, {8{d[0]}}};
         apb(1'b1, XIO_IDX_DIR, 32'(d));
         w = $random(seed);
         apb(1'b1, XIO_IDX_DATA, w);
         out_m = (msk & w[23:0]) | (~msk & out_m);
         ext_drive <= $random(seed);
         @(posedge pclk);
         apb(1'b0, XIO_IDX_DIR, 32'h0);
         chk_reg("dir", 32'(d), rd);
         chk_pin("oe", msk, line_oe);
         chk_pin("out", msk & out_m, msk & line_out);
         apb(1'b0, XIO_IDX_DATA, 32'h0);
         chk_reg("data", {8'h00, (msk & out_m) | (~msk & ext_drive)}, rd);
      end
      $display("test lines done");
      for (k = 0; k < 4; k++)
      begin
         // levels 2 and 3 push past both ends of the range
         v = (k == 3) ? 20000 : (k == 2) ? -15000 : $random(seed) % 10001;
         apb(1'b1, XIO_IDX_LEVEL0 + 18'(k), 32'(v));
         lvl_m[k] = (v > 10000) ? 10000 : (v < -10000) ? -10000 : v;
         apb(1'b0, XIO_IDX_LEVEL0 + 18'(k), 32'h0);
         chk_reg("level", 32'(lvl_m[k]), rd);
      end
      chk_dac();
      apb(1'b1, XIO_IDX_UPDATE, 32'h2);
      apb(1'b1, XIO_IDX_UPDATE, 32'h0);
      chk_dac();
      chk_reg("loads", 32'h0, 32'(load_cnt));
      apb(1'b1, XIO_IDX_UPDATE, 32'h1);
      repeat (2) @(posedge pclk);
      for (k = 0; k < 4; k++)
         code_m[k] = int'(((longint'(lvl_m[k]) + 10000) * 214696) >>> 20);
      chk_dac();
      chk_reg("loads", 32'h1, 32'(load_cnt));
      chk_pin("out", msk & out_m, msk & line_out);
      $display("test levels done");
      apb(1'b0, XIO_IDX_UPDATE, 32'h0);
      chk_reg("upd_rd", 32'h0, rd);
      chk_reg("upd_err", 32'h0, 32'(er));
      apb(1'b0, 18'h0B900, 32'h0);
      chk_reg("bad_err", 32'h1, 32'(er));
      chk_reg("bad_rd", 32'h0, rd);
      apb(1'b1, 18'h0B900, 32'h1);
      chk_reg("bad_wr_err", 32'h1, 32'(er));
      chk_dac();
      $display("test unmapped done");
      finish_test();
   end
endmodule : tb_top

`default_nettype wire
